//--- hdl/wcd_mem_if.sv
`timescale 1ns/100ps
interface wcd_mem_if #(
  parameter int REG_W = 9,
  parameter int NUM = 2,
  parameter int AW = 1
);
  logic [AW-1:0] addr;
  logic we;
  logic [REG_W-1:0] wdata;
  logic [REG_W-1:0] rdata;
  logic [NUM*REG_W-1:0] wipers;

  modport ctrl (
    output addr,
    output we,
    output wdata,
    input rdata,
    input wipers
  );
  modport mem (
    input addr,
    input we,
    input wdata,
    output rdata,
    output wipers
  );
endinterface

//--- hdl/wcd_pkg.sv
package wcd_pkg;
  localparam int WCD_WIPER_BITS = 8;
  localparam int WCD_REG_W = 9;
  localparam int WCD_NUM_WIPERS = 2;
  localparam int WCD_MEM_ADDR_W = 1;
  localparam int WCD_ADDR_W = 4;
  localparam int WCD_FRAME_W = 16;
  localparam int WCD_OP_MSB = 1;
  localparam int WCD_OP_LSB = 0;
  localparam int WCD_ADDR_MSB = 5;
  localparam int WCD_ADDR_LSB = 2;
  localparam logic [1:0] WCD_OP_WRITE = 2'h0;
  localparam logic [1:0] WCD_OP_INC = 2'h1;
  localparam logic [1:0] WCD_OP_DEC = 2'h2;
  localparam logic [1:0] WCD_OP_READ = 2'h3;
  localparam logic [3:0] WCD_CNT_DECODE = 4'h5;
  localparam logic [3:0] WCD_CNT_ERR_SLOT = 4'h6;
  localparam logic [3:0] WCD_CNT_CMD_END = 4'h7;
  localparam logic [3:0] WCD_CNT_FRAME_END = 4'hf;
  localparam logic [3:0] WCD_CNT_RESET = 4'h0;
  localparam logic WCD_SDO_IDLE = 1'b1;

  typedef enum logic [1:0] {
    WCD_ST_CMD,
    WCD_ST_DATA,
    WCD_ST_ERR
  } wcd_state_t;
endpackage

//--- hdl/wcd_top.sv
`timescale 1ns/100ps
module wcd_top #(
  parameter int WIPER_BITS = wcd_pkg::WCD_WIPER_BITS
) (
  input wire logic i_sys_clk,
  input wire logic i_rst,
  input wire logic i_cs_n,
  input wire logic i_sck,
  input wire logic i_sdi,
  output logic o_sdo,
  output logic o_sdo_oe,
  output logic [wcd_pkg::WCD_REG_W-1:0] o_wiper0,
  output logic [wcd_pkg::WCD_REG_W-1:0] o_wiper1
);
  import wcd_pkg::*;

  localparam logic [WCD_REG_W-1:0] FULL =
    WCD_REG_W'(1 << WIPER_BITS);

  wcd_mem_if #(
    .REG_W(WCD_REG_W),
    .NUM(WCD_NUM_WIPERS),
    .AW(WCD_MEM_ADDR_W)
  ) mem_bus ();

  wcd_wiper_mem #(
    .WIPER_BITS(WIPER_BITS)
  ) u_mem (
    .i_sys_clk(i_sys_clk),
    .i_rst(i_rst),
    .bus(mem_bus)
  );

  wcd_state_t state;
  wcd_state_t next_state;
  logic [3:0] cnt;
  logic [3:0] next_cnt;
  logic [WCD_FRAME_W-1:0] shreg;
  logic [WCD_FRAME_W-1:0] next_shreg;
  logic [1:0] op;
  logic [1:0] next_op;
  logic [WCD_ADDR_W-1:0] addr;
  logic [WCD_ADDR_W-1:0] next_addr;
  logic sdo;
  logic next_sdo;
  logic sck_q;
  logic rise;
  logic fall;
  logic cmd_end;
  logic dec_apply;
  logic inc_apply;
  logic wr_apply;
  logic [5:0] head;
  logic [WCD_FRAME_W-1:0] frame;
  logic [WCD_REG_W-1:0] cur_wiper;

  // At zero scale or above full scale the value is held.
  function automatic logic [WCD_REG_W-1:0] step_down(
    input logic [WCD_REG_W-1:0] v
  );
    if (v == '0 || v > FULL) begin
      return v;
    end
    return v - 1'b1;
  endfunction

  function automatic logic [WCD_REG_W-1:0] step_up(
    input logic [WCD_REG_W-1:0] v
  );
    if (v >= FULL) begin
      return v;
    end
    return v + 1'b1;
  endfunction

  // SCK is sampled by the system clock, so it must stay well below it.
  assign rise = i_sck & ~sck_q;
  assign fall = ~i_sck & sck_q;
  assign head = {shreg[4:0], i_sdi};
  assign frame = {shreg[WCD_FRAME_W-2:0], i_sdi};
  assign cmd_end = !i_cs_n && rise && state == WCD_ST_CMD &&
    cnt == WCD_CNT_CMD_END;
  assign dec_apply = cmd_end && op == WCD_OP_DEC;
  assign inc_apply = cmd_end && op == WCD_OP_INC;
  assign wr_apply = !i_cs_n && rise && state == WCD_ST_DATA &&
    cnt == WCD_CNT_FRAME_END && op == WCD_OP_WRITE;
  assign mem_bus.addr = addr[WCD_MEM_ADDR_W-1:0];
  assign o_wiper0 = mem_bus.wipers[WCD_REG_W-1:0];
  assign o_wiper1 = mem_bus.wipers[2*WCD_REG_W-1:WCD_REG_W];
  assign cur_wiper = addr[0] ? o_wiper1 : o_wiper0;
  assign o_sdo = sdo;
  // Open drain: the pin is pulled low only while a zero is presented.
  assign o_sdo_oe = ~sdo;

  always_comb begin
    mem_bus.we = dec_apply | inc_apply | wr_apply;
    if (dec_apply) begin
      mem_bus.wdata = step_down(mem_bus.rdata);
    end else if (inc_apply) begin
      mem_bus.wdata = step_up(mem_bus.rdata);
    end else begin
      mem_bus.wdata = frame[WCD_REG_W-1:0];
    end
  end

  always_comb begin
    next_state = state;
    next_cnt = cnt;
    next_shreg = shreg;
    next_op = op;
    next_addr = addr;
    next_sdo = sdo;
    if (i_cs_n) begin
      // Raising chip select ends any frame and clears the error.
      next_state = WCD_ST_CMD;
      next_cnt = WCD_CNT_RESET;
      next_sdo = WCD_SDO_IDLE;
    end else if (state == WCD_ST_ERR) begin
      if (fall) begin
        next_sdo = 1'b0;
      end
    end else begin
      if (rise) begin
        next_shreg = frame;
        next_cnt = cnt + 1'b1;
        if (cnt == WCD_CNT_DECODE) begin
          next_addr = head[WCD_ADDR_MSB:WCD_ADDR_LSB];
          next_op = head[WCD_OP_MSB:WCD_OP_LSB];
          if (head[WCD_ADDR_MSB:WCD_ADDR_LSB] >= WCD_NUM_WIPERS) begin
            next_state = WCD_ST_ERR;
          end
        end
        if (cmd_end) begin
          if (op == WCD_OP_DEC || op == WCD_OP_INC) begin
            next_cnt = WCD_CNT_RESET;
          end else begin
            next_state = WCD_ST_DATA;
          end
        end
        if (state == WCD_ST_DATA && cnt == WCD_CNT_FRAME_END) begin
          next_state = WCD_ST_CMD;
          next_cnt = WCD_CNT_RESET;
        end
      end
      if (fall) begin
        if (op == WCD_OP_READ && cnt >= WCD_CNT_CMD_END) begin
          next_sdo = mem_bus.rdata[WCD_CNT_FRAME_END - cnt];
        end else begin
          // A valid command shows a high error bit in clock seven.
          next_sdo = WCD_SDO_IDLE;
        end
      end
    end
  end

  always_ff @(posedge i_sys_clk) begin
    if (i_rst) begin
      state <= WCD_ST_CMD;
      cnt <= WCD_CNT_RESET;
      shreg <= '0;
      op <= WCD_OP_WRITE;
      addr <= '0;
      sdo <= WCD_SDO_IDLE;
      sck_q <= 1'b0;
    end else begin
      state <= next_state;
      cnt <= next_cnt;
      shreg <= next_shreg;
      op <= next_op;
      addr <= next_addr;
      sdo <= next_sdo;
      sck_q <= i_sck;
    end
  end

  a_dec_step_one: assert property (
    @(posedge i_sys_clk) disable iff (i_rst)
    dec_apply && mem_bus.rdata != '0 && mem_bus.rdata <= FULL
    |=> cur_wiper == $past(mem_bus.rdata) - 1'b1
  ) else $error("decrement did not lower wiper by one");

  a_dec_zero_hold: assert property (
    @(posedge i_sys_clk) disable iff (i_rst)
    dec_apply && mem_bus.rdata == '0 |=> cur_wiper == '0 [*2]
  ) else $error("wiper wrapped below zero scale");

  a_dec_above_full: assert property (
    @(posedge i_sys_clk) disable iff (i_rst)
    dec_apply && mem_bus.rdata > FULL |=> $stable(cur_wiper)
  ) else $error("decrement changed a wiper above full scale");

  a_full_scale_dec: assert property (
    @(posedge i_sys_clk) disable iff (i_rst)
    dec_apply && mem_bus.rdata == FULL |=> cur_wiper == FULL - 1'b1
  ) else $error("decrement from full scale failed");

  a_bad_addr_err: assert property (
    @(posedge i_sys_clk) disable iff (i_rst)
    !i_cs_n && rise && state == WCD_ST_CMD && cnt == WCD_CNT_DECODE &&
    head[WCD_ADDR_MSB:WCD_ADDR_LSB] >= WCD_NUM_WIPERS
    |=> state == WCD_ST_ERR && !mem_bus.we
  ) else $error("invalid address not flagged");

  a_err_sdo_low: assert property (
    @(posedge i_sys_clk) disable iff (i_rst)
    state == WCD_ST_ERR && !i_cs_n && fall |=> !o_sdo && o_sdo_oe
  ) else $error("serial output not low after error");

  a_err_cleared: assert property (
    @(posedge i_sys_clk) disable iff (i_rst)
    i_cs_n |=> state == WCD_ST_CMD && cnt == WCD_CNT_RESET && o_sdo
  ) else $error("chip select high did not clear error");

  a_err_bit_slot: assert property (
    @(posedge i_sys_clk) disable iff (i_rst)
    state == WCD_ST_CMD && !i_cs_n && fall && cnt == WCD_CNT_ERR_SLOT
    |=> o_sdo
  ) else $error("error bit wrong for valid command");

  a_chain_restart: assert property (
    @(posedge i_sys_clk) disable iff (i_rst)
    dec_apply |=> cnt == WCD_CNT_RESET && state == WCD_ST_CMD
  ) else $error("decrement did not end its command byte");

  a_read_d8_bit: assert property (
    @(posedge i_sys_clk) disable iff (i_rst)
    state == WCD_ST_CMD && !i_cs_n && fall && op == WCD_OP_READ &&
    cnt == WCD_CNT_CMD_END |=> o_sdo == $past(mem_bus.rdata[8])
  ) else $error("read did not present wiper bit 8");
endmodule

//--- hdl/wcd_wiper_mem.sv
`timescale 1ns/100ps
module wcd_wiper_mem #(
  parameter int WIPER_BITS = wcd_pkg::WCD_WIPER_BITS
) (
  input wire logic i_sys_clk,
  input wire logic i_rst,
  wcd_mem_if.mem bus
);
  import wcd_pkg::*;

  // Volatile wipers power up at mid-scale.
  localparam logic [WCD_REG_W-1:0] MID =
    WCD_REG_W'(1 << (WIPER_BITS - 1));

  logic [WCD_REG_W-1:0] regs [WCD_NUM_WIPERS];
  logic [WCD_REG_W-1:0] next_regs [WCD_NUM_WIPERS];
  logic [WCD_REG_W-1:0] rdata;
  logic [WCD_REG_W-1:0] next_rdata;

  always_comb begin
    for (int i = 0; i < WCD_NUM_WIPERS; i++) begin
      next_regs[i] = regs[i];
    end
    if (bus.we) begin
      next_regs[bus.addr] = bus.wdata;
    end
    // Read data reflect a write of the same cycle, so a chained command
    // never sees a stale wiper.
    next_rdata = next_regs[bus.addr];
  end

  always_ff @(posedge i_sys_clk) begin
    if (i_rst) begin
      for (int i = 0; i < WCD_NUM_WIPERS; i++) begin
        regs[i] <= MID;
      end
      rdata <= MID;
    end else begin
      regs <= next_regs;
      rdata <= next_rdata;
    end
  end

  assign bus.rdata = rdata;
  always_comb begin
    for (int i = 0; i < WCD_NUM_WIPERS; i++) begin
      bus.wipers[i*WCD_REG_W +: WCD_REG_W] = regs[i];
    end
  end
endmodule

//--- verification/wcd_host_model.sv
`timescale 1ns/100ps
module wcd_host_model (
  input wire logic i_sys_clk,
  input wire logic i_sdo,
  output logic o_cs_n,
  output logic o_sck,
  output logic o_sdi
);
  initial begin
    o_cs_n = 1'b1;
    o_sck = 1'b0;
    o_sdi = 1'b0;
  end

  task automatic wait_clk(input int n);
    repeat (n) @(negedge i_sys_clk);
  endtask

  task automatic select();
    wait_clk(2);
    o_cs_n = 1'b0;
    wait_clk(2);
  endtask

  // Chip select goes high soon after the last command, so a stray clock
  // edge cannot move the wiper; data is flipped so no stale level lingers.
  task automatic release_cs();
    wait_clk(3);
    o_cs_n = 1'b1;
    o_sdi = ~o_sdi;
    wait_clk(3);
  endtask

  // Sends n bits MSB first, three system cycles per clock phase, and keeps
  // the output bit seen just before each rising clock edge.
  task automatic xfer(input logic [15:0] d, input int n,
      output logic [15:0] q);
    q = 16'h0000;
    for (int i = 0; i < n; i++) begin
      o_sdi = d[15-i];
      wait_clk(3);
      q[15-i] = i_sdo;
      o_sck = 1'b1;
      wait_clk(3);
      o_sck = 1'b0;
    end
  endtask
endmodule

//--- verification/wcd_top_tb_top.sv
`timescale 1ns/100ps
module wcd_top_tb_top;
  import wcd_pkg::*;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic [1:0] cs_n, sck, sdi, sdo, oe;
  logic [WCD_REG_W-1:0] w0 [2];
  logic [WCD_REG_W-1:0] w1 [2];
  logic [8:0] m [2][2];
  int error_cnt = 0;
  int checks_done = 0;

  always #4 clk = ~clk;

  // Instance 0 is the 8-bit wiper variant, instance 1 the 7-bit one.
  for (genvar g = 0; g < 2; g++) begin : gen_u
    wcd_top #(.WIPER_BITS(8 - g)) dut_u (.i_sys_clk(clk), .i_rst(rst),
      .i_cs_n(cs_n[g]), .i_sck(sck[g]), .i_sdi(sdi[g]), .o_sdo(sdo[g]),
      .o_sdo_oe(oe[g]), .o_wiper0(w0[g]), .o_wiper1(w1[g]));
    wcd_host_model h_u (.i_sys_clk(clk), .i_sdo(sdo[g]),
      .o_cs_n(cs_n[g]), .o_sck(sck[g]), .o_sdi(sdi[g]));
  end

  task automatic print_verdict();
    $display("checks %0d mismatches %0d", checks_done, error_cnt);
    if (error_cnt == 0 && checks_done > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask

  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    checks_done++;
    if (seen !== exp) begin
      error_cnt++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  function automatic logic [8:0] fs(input int s);
    return s == 0 ? 9'h100 : 9'h080;
  endfunction

  function automatic logic [8:0] exp_dec(input int s, input logic [8:0] v);
    return (v == 9'h000 || v > fs(s)) ? v : v - 9'h001;
  endfunction

  task automatic xf(input int s, input logic [15:0] d, input int n,
      output logic [15:0] q);
    if (s == 0) gen_u[0].h_u.xfer(d, n, q);
    else gen_u[1].h_u.xfer(d, n, q);
  endtask

  task automatic cs(input int s, input bit lo);
    if (s == 0 && lo) gen_u[0].h_u.select();
    else if (s == 0) gen_u[0].h_u.release_cs();
    else if (lo) gen_u[1].h_u.select();
    else gen_u[1].h_u.release_cs();
  endtask

  task automatic dec(input int s, input logic a, output logic [15:0] q);
    xf(s, {3'h0, a, WCD_OP_DEC, 10'h000}, 8, q);
    m[s][a] = exp_dec(s, m[s][a]);
  endtask

  task automatic chk_w(input int s);
    check(16'(w0[s]), 16'(m[s][0]));
    check(16'(w1[s]), 16'(m[s][1]));
  endtask

  task automatic t_reset();
    for (int s = 0; s < 2; s++) begin
      m[s][0] = 9'h080 >> s;
      m[s][1] = 9'h080 >> s;
      chk_w(s);
      check(16'({sdo[s], oe[s]}), 16'h0002);
    end
  endtask

  task automatic t_chain(input int s);
    logic [15:0] q;
    logic a;
    cs(s, 1'b1);
    for (int i = 0; i < 6; i++) begin
      a = (i % 3) != 1;
      dec(s, a, q);
      chk_w(s);
      check(16'(q[15:9]), 16'h007f);
    end
    xf(s, {4'h1, WCD_OP_READ, 10'h000}, 16, q);
    check(16'(q[8:0]), 16'(m[s][1]));
    // The increment path is decoded too, so it must be driven at least once.
    xf(s, {4'h0, WCD_OP_INC, 10'h000}, 8, q);
    m[s][0] = m[s][0] + 9'h001;
    chk_w(s);
    check(16'(q[15:9]), 16'h007f);
    cs(s, 1'b0);
  endtask

  task automatic t_abort();
    logic [15:0] q;
    cs(0, 1'b1);
    xf(0, {4'h0, WCD_OP_DEC, 10'h000}, 7, q);
    chk_w(0);
    cs(0, 1'b0);
    chk_w(0);
  endtask

  task automatic t_error(input int s);
    logic [15:0] q;
    for (int i = 0; i < 2; i++) begin
      cs(s, 1'b1);
      xf(s, {i ? 4'hf : 4'h2, WCD_OP_DEC, 10'h000}, 8, q);
      check(q, 16'hfc00);
      check(16'(oe[s]), 16'h0001);
      xf(s, {4'h0, WCD_OP_DEC, 10'h000}, 8, q);
      check(q, 16'h0000);
      chk_w(s);
      cs(s, 1'b0);
      check(16'(sdo[s]), 16'h0001);
      cs(s, 1'b1);
      dec(s, 1'b0, q);
      chk_w(s);
      cs(s, 1'b0);
    end
  endtask

  task automatic t_bounds(input int s);
    logic [15:0] q;
    logic [8:0] tv [5];
    tv = '{fs(s), fs(s) + 9'h001, 9'h1ff, 9'h000, 9'h001};
    for (int i = 0; i < 5; i++) begin
      cs(s, 1'b1);
      xf(s, {4'h0, WCD_OP_WRITE, 1'b0, tv[i]}, 16, q);
      m[s][0] = tv[i];
      dec(s, 1'b0, q);
      chk_w(s);
      dec(s, 1'b0, q);
      xf(s, {4'h0, WCD_OP_READ, 10'h000}, 16, q);
      check(16'(q[8:0]), 16'(m[s][0]));
      cs(s, 1'b0);
    end
  endtask

  initial begin
    repeat (16) @(negedge clk);
    rst = 1'b0;
    t_reset();
    t_abort();
    for (int s = 0; s < 2; s++) begin
      t_chain(s);
      t_error(s);
      t_bounds(s);
    end
    print_verdict();
  end

  // A hang is cut short here and counted as a mismatch.
  initial begin
    repeat (100000) @(posedge clk);
    error_cnt++;
    print_verdict();
  end
endmodule
